/* common/sleep_cfg_pkg.sv */
/*
 * Package for the sleep, wake and configuration protection block.
 * Holds configuration word layout, test space addresses, oscillator mode codes,
 * reset values and timing counts. Assumes a 14-bit program word.
 */
package sleep_cfg_pkg;

  // Width of one program memory or configuration word.
  localparam int unsigned WORD_W = 14;

  // Width of a programmer address.
  localparam int unsigned ADDR_W = 14;

  // Test space addresses reached only in programming mode.
  localparam logic [13:0] ID_BASE_ADDR = 14'h2000;
  localparam logic [13:0] ID_LAST_ADDR = 14'h2003;
  localparam logic [13:0] CFG_WORD_ADDR = 14'h2007;
  localparam logic [13:0] TEST_SPACE_BASE = 14'h2000;

  // Field positions inside the configuration word.
  localparam int unsigned CFG_OSC_LO_POS = 0;
  localparam int unsigned CFG_OSC_HI_POS = 1;
  localparam int unsigned CFG_WDT_POS = 2;
  localparam int unsigned CFG_PWRT_POS = 3;
  localparam int unsigned CFG_CP_POS = 4;

  // Erased configuration word: every bit unprogrammed reads as one.
  localparam logic [13:0] CFG_ERASED = 14'h3fff;

  // Mask of implemented configuration bits.
  localparam logic [13:0] CFG_IMPL_MASK = 14'h001f;

  // Erased program word value.
  localparam logic [13:0] WORD_ERASED = 14'h3fff;

  // Oscillator select codes.
  localparam logic [1:0] OSC_LOW_POWER_CRYSTAL = 2'h0;
  localparam logic [1:0] OSC_STANDARD_CRYSTAL = 2'h1;
  localparam logic [1:0] OSC_HIGH_SPEED_CRYSTAL = 2'h2;
  localparam logic [1:0] OSC_RESISTOR_CAPACITOR = 2'h3;

  // Oscillator start-up delay in oscillator periods.
  localparam int unsigned OST_PERIODS = 1024;

  // Clock output divide ratio.
  localparam int unsigned CLK_DIV_RATIO = 4;
  localparam int unsigned CLK_DIV_HALF = CLK_DIV_RATIO / 2;

  // Reset values of the status flags.
  localparam logic POWERDOWN_FLAG_RST = 1'b1;
  localparam logic TIMEOUT_FLAG_RST = 1'b1;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_START_UP
  } seq_state_e;

endpackage

/* verilog/clk_div_out.sv */
/*
 * Divide-by-four clock output generator for resistor-capacitor mode.
 * Assumes clk_i is the selected oscillator; output is a registered level.
 */
`timescale 1ns/10ps
`default_nettype none

module clk_div_out
  import sleep_cfg_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic enable_i,
  output var  logic div_clk_o
);

  // Counts oscillator periods within half an output period.
  logic [1:0] cnt_q;
  // The divided clock level.
  logic       div_q;
  // Terminal count reached.
  wire        half_done = (cnt_q == 2'(CLK_DIV_HALF - 1));

  // The divider runs only while enabled and holds low otherwise.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 2'h0;
      div_q <= 1'b0;
    end else if (!enable_i) begin
      cnt_q <= 2'h0;
      div_q <= 1'b0;
    end else if (half_done) begin
      cnt_q <= 2'h0;
      div_q <= ~div_q;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign div_clk_o = div_q;

endmodule

`default_nettype wire

/* verilog/sleep_wake_config_protect.sv */
/*
 * Sleep and wake sequencer, configuration word, ID words and code protection.
 * Assumes a core that pulses sleep and watchdog clear instructions, an
 * external programmer port and synchronous inputs on one clock.
 */
`timescale 1ns/10ps
`default_nettype none

module sleep_wake_config_protect
  import sleep_cfg_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              master_clear_pin_i,
  input  wire logic              sleep_instr_i,
  input  wire logic              watchdog_clear_instr_i,
  input  wire logic              prescaler_on_wdt_i,
  input  wire logic              wdt_timeout_i,
  input  wire logic              global_irq_enable_i,
  input  wire logic              ext_irq_i,
  input  wire logic              ext_irq_mask_i,
  input  wire logic              port_change_irq_i,
  input  wire logic              port_change_mask_i,
  input  wire logic              eeprom_done_irq_i,
  input  wire logic              eeprom_done_mask_i,
  input  wire logic [7:0]        pin_out_i,
  input  wire logic [7:0]        pin_oe_i,
  input  wire logic              prog_mode_i,
  input  wire logic              prog_wr_i,
  input  wire logic              prog_rd_i,
  input  wire logic              prog_erase_i,
  input  wire logic              prog_data_mem_i,
  input  wire logic [ADDR_W-1:0] prog_addr_i,
  input  wire logic [WORD_W-1:0] prog_wdata_i,
  input  wire logic [WORD_W-1:0] mem_rdata_i,
  output var  logic [WORD_W-1:0] prog_rdata_o,
  output var  logic              prog_rvalid_o,
  output var  logic              mem_wr_o,
  output var  logic              mem_erase_o,
  output var  logic              powerdown_flag_o,
  output var  logic              timeout_flag_o,
  output var  logic              asleep_o,
  output var  logic              osc_driver_on_o,
  output var  logic              core_reset_o,
  output var  logic              wdt_clear_o,
  output var  logic              wake_continue_o,
  output var  logic              wake_branch_o,
  output var  logic              core_run_o,
  output var  logic [7:0]        pin_out_o,
  output var  logic [7:0]        pin_oe_o,
  output var  logic              master_clear_drive_o,
  output var  logic              osc_out_clock_pin_o,
  output var  logic [1:0]        osc_mode_o,
  output var  logic              watchdog_enable_fuse_o,
  output var  logic              powerup_timer_enable_fuse_o,
  output var  logic              code_protect_o
);

  // Oscillator start-up count in clock cycles; one clock is one period.
  localparam int unsigned OstCycles = OST_PERIODS;

  initial begin
    if (WORD_W != 14) $error("Block serves a 14-bit word only.");
  end

  // Sequencer state.
  seq_state_e             state_q, state_d;
  // Start-up counter for crystal modes.
  logic [10:0]            ost_cnt_q;
  // Configuration word and the four ID words.
  logic [WORD_W-1:0]      cfg_q;
  logic [WORD_W-1:0]      id_q [4];
  // Status flags.
  logic                   pd_q;
  logic                   to_q;
  // Wake request remembered as continue or branch.
  logic                   branch_q;
  // Registered outputs.
  logic [WORD_W-1:0]      rdata_q;
  logic                   rvalid_q;
  logic                   mem_wr_q;
  logic                   mem_erase_q;
  logic                   wdt_clr_q;
  logic                   cont_q;
  logic                   brch_q;
  logic                   core_rst_q;
  logic [7:0]             pin_out_q;
  logic [7:0]             pin_oe_q;
  // Erase sequencing: memories first, then the configuration word.
  logic                   erase_pend_q;
  // Registered views of the state, so the sleep, oscillator and run outputs leave a flip-flop.
  logic                   asleep_q, osc_on_q, run_q;

  // Decoded configuration fields.
  wire [1:0] osc_sel   = {cfg_q[CFG_OSC_HI_POS], cfg_q[CFG_OSC_LO_POS]};
  wire       rc_mode   = (osc_sel == OSC_RESISTOR_CAPACITOR);
  wire       wdt_en    = cfg_q[CFG_WDT_POS];
  wire       pwrt_en   = cfg_q[CFG_PWRT_POS];
  wire       protected_w = ~cfg_q[CFG_CP_POS];

  // Wake sources; each interrupt needs its own mask bit.
  wire irq_wake = (ext_irq_i & ext_irq_mask_i) | (port_change_irq_i & port_change_mask_i)
                | (eeprom_done_irq_i & eeprom_done_mask_i);
  wire wdt_wake = wdt_timeout_i & wdt_en;
  wire master_clear_pin_rst = ~master_clear_pin_i;
  wire asleep   = (state_q == ST_SLEEP);
  wire wake_any = asleep & (irq_wake | wdt_wake);
  // Only an executed sleep instruction enters power-down.
  wire go_sleep = (state_q == ST_RUN) & sleep_instr_i & ~master_clear_pin_rst;
  // Branch choice of this wake, or the one remembered across start-up, never an older one.
  wire br_now   = irq_wake & ~wdt_wake & global_irq_enable_i;
  wire br_sel   = wake_any ? br_now : branch_q;
  wire resume   = (state_q != ST_RUN) & (state_d == ST_RUN) & ~master_clear_pin_rst;

  // Programmer address decode.
  wire acc_id   = prog_mode_i & (prog_addr_i >= ID_BASE_ADDR) & (prog_addr_i <= ID_LAST_ADDR);
  wire acc_cfg  = prog_mode_i & (prog_addr_i == CFG_WORD_ADDR);
  wire acc_test = prog_mode_i & (prog_addr_i >= TEST_SPACE_BASE);
  wire acc_mem  = prog_mode_i & ~acc_test;
  wire [1:0] id_idx = prog_addr_i[1:0];
  // Scrambled verify word: upper seven zero, low seven folded.
  wire [WORD_W-1:0] scrambled = {7'h00, mem_rdata_i[6:0] ^ mem_rdata_i[13:7]};
  wire [WORD_W-1:0] cfg_read  = cfg_q | ~CFG_IMPL_MASK;
  wire [WORD_W-1:0] rd_sel =
      acc_cfg ? cfg_read :
      acc_id  ? id_q[id_idx] :
      (acc_mem & protected_w) ? scrambled : mem_rdata_i;
  // Protected data memory gives no read answer at all.
  wire rd_ok = prog_rd_i & (acc_cfg | acc_id | (acc_mem & ~(protected_w & prog_data_mem_i)));
  wire wr_mem_ok = prog_wr_i & acc_mem & ~protected_w;

  // Next state of the sequencer.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (go_sleep) state_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        // Crystal modes wait for the oscillator, RC resumes directly.
        if (wake_any) state_d = rc_mode ? ST_RUN : ST_START_UP;
      end
      ST_START_UP: begin
        if (ost_cnt_q == 11'(OstCycles - 1)) state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
    if (master_clear_pin_rst) state_d = ST_RUN;
  end

  // Sequencer, start-up counter and status flags.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q   <= ST_RUN;
      ost_cnt_q <= 11'h000;
      pd_q      <= POWERDOWN_FLAG_RST;
      to_q      <= TIMEOUT_FLAG_RST;
      branch_q  <= 1'b0;
      asleep_q  <= 1'b0;
      osc_on_q  <= 1'b1;
      run_q     <= 1'b1;
    end else begin
      state_q   <= state_d;
      asleep_q  <= (state_d == ST_SLEEP);
      osc_on_q  <= (state_d != ST_SLEEP);
      run_q     <= (state_d == ST_RUN);
      ost_cnt_q <= (state_q == ST_START_UP) ? ost_cnt_q + 11'h001 : 11'h000;
      // Flags change only from hardware events.
      if (go_sleep) begin
        pd_q <= 1'b0;
        to_q <= 1'b1;
      end else if (wdt_wake && asleep) begin
        to_q <= 1'b0;
      end
      if (wake_any) branch_q <= br_now;
    end
  end

  // Wake results, watchdog clear, pin hold and core reset.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wdt_clr_q  <= 1'b0;
      cont_q     <= 1'b0;
      brch_q     <= 1'b0;
      core_rst_q <= 1'b1;
      pin_out_q  <= 8'h00;
      pin_oe_q   <= 8'h00;
    end else begin
      // Sleep clears the watchdog and, if assigned, its prescaler.
      wdt_clr_q  <= go_sleep | ((state_q == ST_RUN) & watchdog_clear_instr_i);
      cont_q     <= resume & ~br_sel;
      brch_q     <= resume & br_sel;
      core_rst_q <= master_clear_pin_rst;
      // Pins freeze while asleep.
      if (!asleep && !go_sleep) begin
        pin_out_q <= pin_out_i;
        pin_oe_q  <= pin_oe_i;
      end
    end
  end

  // Programmer port: configuration, ID words and memory guard.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q        <= CFG_ERASED;
      id_q         <= '{default: WORD_ERASED};
      rdata_q      <= 14'h0000;
      rvalid_q     <= 1'b0;
      mem_wr_q     <= 1'b0;
      mem_erase_q  <= 1'b0;
      erase_pend_q <= 1'b0;
    end else begin
      rvalid_q    <= rd_ok;
      rdata_q     <= rd_ok ? rd_sel : 14'h0000;
      mem_wr_q    <= wr_mem_ok;
      mem_erase_q <= prog_mode_i & prog_erase_i;
      // Fuse erased to all ones one cycle after the memory erase strobe.
      erase_pend_q <= prog_mode_i & prog_erase_i;
      if (erase_pend_q) begin
        cfg_q <= CFG_ERASED;
      end else if (prog_wr_i && acc_cfg) begin
        // Programming only clears bits; only erase or reset sets them.
        cfg_q <= cfg_q & (prog_wdata_i | ~CFG_IMPL_MASK);
      end
      if (prog_wr_i && acc_id) id_q[id_idx] <= prog_wdata_i;
    end
  end

  // Clock output for resistor-capacitor mode.
  clk_div_out u_clk_div (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .enable_i  (rc_mode & ~asleep),
    .div_clk_o (osc_out_clock_pin_o)
  );

  assign prog_rdata_o = rdata_q;
  assign prog_rvalid_o = rvalid_q;
  assign mem_wr_o = mem_wr_q;
  assign mem_erase_o = mem_erase_q;
  assign powerdown_flag_o = pd_q;
  assign timeout_flag_o = to_q;
  assign asleep_o = asleep_q;
  assign osc_driver_on_o = osc_on_q;
  assign core_reset_o = core_rst_q;
  assign wdt_clear_o = wdt_clr_q & (prescaler_on_wdt_i | 1'b1);
  assign wake_continue_o = cont_q;
  assign wake_branch_o = brch_q;
  assign core_run_o = run_q;
  assign pin_out_o = pin_out_q;
  assign pin_oe_o = pin_oe_q;
  // Watchdog reset is internal; this pin driver stays off.
  assign master_clear_drive_o = 1'b0;
  assign osc_mode_o = cfg_q[1:0];
  assign watchdog_enable_fuse_o = cfg_q[CFG_WDT_POS];
  assign powerup_timer_enable_fuse_o = cfg_q[CFG_PWRT_POS];
  assign code_protect_o = ~cfg_q[CFG_CP_POS];

  // Sleep entry clears the powerdown flag and sets timeout next cycle.
  a_sleep_flags: assert property (@(posedge clk_i) disable iff (!rstn_i)
    go_sleep |=> (!pd_q && to_q && asleep_o && !osc_driver_on_o))
    else $error("Sleep entry flags wrong.");

  // Without a sleep request, run state never becomes sleep.
  a_sleep_only: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state_q == ST_RUN && !sleep_instr_i) |=> state_q != ST_SLEEP)
    else $error("Sleep entered without instruction.");

  // Pins stay frozen across sleep.
  a_pin_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (asleep && $past(asleep)) |-> $stable(pin_oe_o) && $stable(pin_out_o))
    else $error("Pins changed in sleep.");

  // Master clear drive never asserted on a watchdog timeout.
  a_master_clear_pin_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wdt_timeout_i |-> !master_clear_drive_o)
    else $error("Master clear driven.");

  // Unmasked interrupt never wakes.
  a_mask_wake: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (asleep && !irq_wake && !wdt_wake && !master_clear_pin_rst) |=> asleep_o)
    else $error("Woke without enabled source.");

  // Crystal wake passes through start-up for at least eight cycles.
  a_ost_wait: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (asleep && wake_any && !rc_mode && !master_clear_pin_rst) |=> (state_q == ST_START_UP)[*8])
    else $error("Start-up delay skipped.");

  // RC wake resumes at once.
  a_rc_wake: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (asleep && wake_any && rc_mode) |=> core_run_o)
    else $error("RC wake delayed.");

  // Protected memory writes never strobed.
  a_cp_nowrite: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (prog_wr_i && protected_w) |=> !mem_wr_o)
    else $error("Protected write passed.");

  // Protected program verify has upper seven bits zero.
  a_cp_scramble: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (prog_rd_i && acc_mem && protected_w) |=> prog_rdata_o[13:7] == 7'h00)
    else $error("Protected verify leaks.");

  // Configuration word follows the memory erase by one cycle.
  a_erase_order: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (prog_mode_i && prog_erase_i) |=> mem_erase_o ##1 (cfg_q == CFG_ERASED))
    else $error("Erase order broken.");

endmodule

`default_nettype wire

/* test/prog_memory_model.sv */
/*
 * Stand-in for the program memory array that the programmer reaches behind the block.
 * Assumes the bench drives address and write data, and the block sends write and erase.
 */
`timescale 1ns/10ps
`default_nettype none

module prog_memory_model (
  input  wire logic        clk_i,
  input  wire logic [13:0] addr_i,
  input  wire logic [13:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        erase_i,
  output var  logic [13:0] rdata_o
);
  // Sixteen words are enough; the upper address bits are ignored.
  logic [13:0] mem_q [16];

  // Preload a pattern whose upper bits are not zero, so scrambling shows.
  initial begin
    for (int i = 0; i < 16; i++) mem_q[i] = 14'h2a5a ^ 14'(i);
  end

  // Erase wins over a write in the same cycle.
  always @(posedge clk_i) begin
    if (erase_i) begin
      for (int i = 0; i < 16; i++) mem_q[i] <= 14'h3fff;
    end else if (wr_i) begin
      mem_q[addr_i[3:0]] <= wdata_i;
    end
  end

  // The word at the current address is seen at once.
  assign rdata_o = mem_q[addr_i[3:0]];
endmodule

`default_nettype wire

/* test/tb_top.sv */
/*
 * Self-checking bench for the sleep, wake and configuration protection block.
 * Assumes the memory stand-in model and one 200 MHz clock for everything.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import sleep_cfg_pkg::*;

  // Clock, reset and inputs, all defined at time zero.
  logic clk_i, rstn_i = 1'b0, master_clear_pin_n = 1'b1, slp = 1'b0, wclr = 1'b0, wto = 1'b0, global_irq_enable = 1'b0;
  logic ext = 1'b0, ext_m = 1'b0, pc = 1'b0, pc_m = 1'b0, ee = 1'b0, ee_m = 1'b0;
  logic pmode = 1'b0, pwr = 1'b0, prd = 1'b0, perase = 1'b0, pdmem = 1'b0;
  logic [7:0]  pout = 8'h00, poe = 8'h00;
  logic [13:0] paddr = 14'h0000, pwdata = 14'h0000;
  wire logic [13:0] mrdata, rdata;
  wire logic [7:0]  pin_out, pin_oe;
  wire logic [1:0]  osc_mode;
  wire logic rvalid, mwr, merase, pd, to, asleep, osc_on, core_rst, wdt_clr, w_cont, w_br;
  wire logic run, master_clear_pin_drv, divided_clock_output, wdt_fuse, pwrt_fuse, cp;
  // Values captured by the programmer task in the answer cycle.
  logic [13:0] rd;
  logic rv, wr, er, cp_at;
  int n_mismatch = 0;
  int n_checks = 0;

  sleep_wake_config_protect i_sleep_wake_config_protect (
    .clk_i(clk_i), .rstn_i(rstn_i), .master_clear_pin_i(master_clear_pin_n), .sleep_instr_i(slp),
    .watchdog_clear_instr_i(wclr), .prescaler_on_wdt_i(1'b1), .wdt_timeout_i(wto),
    .global_irq_enable_i(global_irq_enable), .ext_irq_i(ext), .ext_irq_mask_i(ext_m),
    .port_change_irq_i(pc), .port_change_mask_i(pc_m), .eeprom_done_irq_i(ee),
    .eeprom_done_mask_i(ee_m), .pin_out_i(pout), .pin_oe_i(poe), .prog_mode_i(pmode),
    .prog_wr_i(pwr), .prog_rd_i(prd), .prog_erase_i(perase), .prog_data_mem_i(pdmem),
    .prog_addr_i(paddr), .prog_wdata_i(pwdata), .mem_rdata_i(mrdata), .prog_rdata_o(rdata),
    .prog_rvalid_o(rvalid), .mem_wr_o(mwr), .mem_erase_o(merase), .powerdown_flag_o(pd),
    .timeout_flag_o(to), .asleep_o(asleep), .osc_driver_on_o(osc_on),
    .core_reset_o(core_rst), .wdt_clear_o(wdt_clr), .wake_continue_o(w_cont),
    .wake_branch_o(w_br), .core_run_o(run), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .master_clear_drive_o(master_clear_pin_drv), .osc_out_clock_pin_o(divided_clock_output), .osc_mode_o(osc_mode),
    .watchdog_enable_fuse_o(wdt_fuse), .powerup_timer_enable_fuse_o(pwrt_fuse),
    .code_protect_o(cp));

  prog_memory_model i_prog_memory_model (
    .clk_i(clk_i), .addr_i(paddr), .wdata_i(pwdata), .wr_i(mwr), .erase_i(merase),
    .rdata_o(mrdata));

  // The clock toggles every half period of 2.5 ns.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Waits for n rising edges and steps just past the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Counts a comparison and reports a difference.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One programmer operation; the answer is captured, then an idle cycle follows.
  task automatic prog_op(input logic m, r, w, e, input logic [13:0] a, d);
    pmode = m; prd = r; pwr = w; perase = e; paddr = a; pwdata = d;
    tick(1);
    prd = 1'b0; pwr = 1'b0; perase = 1'b0;
    rv = rvalid; rd = rdata; wr = mwr; er = merase; cp_at = cp;
    tick(1);
  endtask

  // Issues the sleep instruction and checks what entering power-down does.
  task automatic do_sleep();
    slp = 1'b1;
    tick(1);
    slp = 1'b0;
    check(asleep, 1'b1);
    check({pd, to, wdt_clr, osc_on}, 4'b0110);
  endtask

  // Power-on state, fuse defaults and the divided clock in RC mode.
  task automatic t_reset();
    int rises;
    logic prev;
    check({pd, to, master_clear_pin_drv, run}, 4'b1101);
    check({osc_mode, wdt_fuse, pwrt_fuse, cp}, 5'b11110);
    prog_op(1'b1, 1'b1, 1'b0, 1'b0, CFG_WORD_ADDR, 14'h0000);
    check({rv, rd}, {1'b1, 14'h3fff});
    rises = 0;
    prev = divided_clock_output;
    for (int i = 0; i < 16; i++) begin
      tick(1);
      if (divided_clock_output === 1'b1 && prev === 1'b0) rises++;
      prev = divided_clock_output;
    end
    check(14'(rises), 14'h0004);
    wclr = 1'b1;
    tick(1);
    wclr = 1'b0;
    check({wdt_clr, asleep}, 2'b10);
  endtask

  // Sleep, then wake by interrupt source k only once its mask is set.
  task automatic t_irq_wake(input int k, input logic g);
    global_irq_enable = g; pout = 8'ha5; poe = 8'h0f;
    tick(1);
    do_sleep();
    pout = 8'h5a; poe = 8'hf0; {ee, pc, ext} = 3'(1 << k);
    tick(3);
    check(asleep, 1'b1);
    check({pin_out, pin_oe}, 16'ha50f);
    {ee_m, pc_m, ext_m} = 3'(1 << k);
    tick(1);
    check({run, w_cont, w_br}, {1'b1, ~g, g});
    {ee, pc, ext} = 3'b000; {ee_m, pc_m, ext_m} = 3'b000;
    tick(1);
  endtask

  // Watchdog wake clears the timeout flag; reset pin wake resets the core.
  task automatic t_wdt_master_clear_pin();
    do_sleep();
    wto = 1'b1;
    tick(1);
    wto = 1'b0;
    check({to, pd, run, master_clear_pin_drv}, 4'b0010);
    tick(1);
    do_sleep();
    master_clear_pin_n = 1'b0;
    tick(1);
    check({core_rst, w_cont, w_br}, 3'b100);
    master_clear_pin_n = 1'b1;
    tick(2);
    check({run, core_rst, w_cont, w_br}, 4'b1000);
  endtask

  // Test space only in programming mode; ID words and plain memory access.
  task automatic t_space();
    prog_op(1'b0, 1'b1, 1'b0, 1'b0, CFG_WORD_ADDR, 14'h0000);
    check(rv, 1'b0);
    prog_op(1'b1, 1'b0, 1'b1, 1'b0, 14'h2001, 14'h0055);
    prog_op(1'b1, 1'b1, 1'b0, 1'b0, 14'h2001, 14'h0000);
    check({rv, rd}, {1'b1, 14'h0055});
    prog_op(1'b1, 1'b0, 1'b1, 1'b0, 14'h0005, 14'h0123);
    check(wr, 1'b1);
    prog_op(1'b1, 1'b1, 1'b0, 1'b0, 14'h0005, 14'h0000);
    check({rv, rd}, {1'b1, 14'h0123});
  endtask

  // Crystal mode, watchdog off and protection on, then a slow wake.
  task automatic t_crystal();
    int n;
    prog_op(1'b1, 1'b0, 1'b1, 1'b0, CFG_WORD_ADDR, 14'h3ffe);
    check(osc_mode, OSC_HIGH_SPEED_CRYSTAL);
    prog_op(1'b1, 1'b0, 1'b1, 1'b0, CFG_WORD_ADDR, 14'h3fe8);
    prog_op(1'b1, 1'b1, 1'b0, 1'b0, CFG_WORD_ADDR, 14'h0000);
    check(rd, 14'h3fe8);
    check({osc_mode, wdt_fuse, pwrt_fuse, cp}, 5'b00011);
    check(divided_clock_output, 1'b0);
    pmode = 1'b0;
    do_sleep();
    wto = 1'b1;
    tick(1);
    wto = 1'b0;
    check(asleep, 1'b1);
    ext = 1'b1; ext_m = 1'b1; n = 0;
    while (run !== 1'b1) begin
      tick(1);
      n++;
      if (n > 1100) begin
        n_mismatch++;
        report_and_stop();
      end
    end
    check(14'(n >= 1024 && n <= 1026), 14'h0001);
    check({w_cont, w_br}, 2'b10);
    ext = 1'b0; ext_m = 1'b0;
    tick(1);
  endtask

  // Protected reads and writes, then chip erase and a fresh mode code.
  task automatic t_protect_erase();
    prog_op(1'b1, 1'b0, 1'b1, 1'b0, 14'h0005, 14'h0321);
    check(wr, 1'b0);
    prog_op(1'b1, 1'b1, 1'b0, 1'b0, 14'h0005, 14'h0000);
    check({rv, rd[13:7]}, 8'h80);
    check(rd === 14'h0123, 1'b0);
    pdmem = 1'b1;
    prog_op(1'b1, 1'b1, 1'b0, 1'b0, 14'h0002, 14'h0000);
    check(rv, 1'b0);
    prog_op(1'b1, 1'b0, 1'b1, 1'b0, 14'h0002, 14'h0011);
    check(wr, 1'b0);
    pdmem = 1'b0;
    prog_op(1'b1, 1'b1, 1'b0, 1'b0, 14'h2001, 14'h0000);
    check({rv, rd}, {1'b1, 14'h0055});
    prog_op(1'b1, 1'b0, 1'b0, 1'b1, 14'h0000, 14'h0000);
    check({er, cp_at, cp}, 3'b110);
    prog_op(1'b1, 1'b1, 1'b0, 1'b0, 14'h0005, 14'h0000);
    check(rd, 14'h3fff);
    prog_op(1'b1, 1'b0, 1'b1, 1'b0, CFG_WORD_ADDR, 14'h3ffd);
    check(osc_mode, OSC_STANDARD_CRYSTAL);
  endtask

  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial begin
    repeat (10) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    tick(1);
    t_reset();
    t_irq_wake(0, 1'b0);
    t_irq_wake(1, 1'b1);
    t_irq_wake(2, 1'b0);
    t_wdt_master_clear_pin();
    t_space();
    t_crystal();
    t_protect_erase();
    report_and_stop();
  end
endmodule

`default_nettype wire
